//--- sysctl_pkg.sv
// Shared constants and types for the processor system-control and port logic.
package sysctl_pkg;

  localparam logic [15:0] RESET_VEC = 16'hfffc;
  localparam logic [15:0] IRQ_VEC = 16'hfffe;
  localparam logic [2:0] INIT_CYCLES = 3'h6;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] STACK_PUSHES = 8'h03;
  localparam int IRQ_MASK_BIT = 2;
  localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
  localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [7:0] PORT_OUT_RESET = 8'h00;

  typedef enum logic [8:0] {
    ST_HOLD  = 9'h001,
    ST_INIT  = 9'h002,
    ST_VECLO = 9'h004,
    ST_VECHI = 9'h008,
    ST_VECEND = 9'h010,
    ST_RUN   = 9'h020,
    ST_PUSH1 = 9'h040,
    ST_PUSH2 = 9'h080,
    ST_PUSH3 = 9'h100
  } ctl_state_e;

endpackage : sysctl_pkg

//--- io_port.sv
// On-chip bidirectional peripheral port with direction and output registers.
`timescale 1ns/1ps
module io_port #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clkEn, // Clock enable, freezes state while low.
  input wire logic [15:0] busAddr, // Address of the current bus cycle.
  input wire logic busWrite, // Current bus cycle is a write.
  input wire logic [WIDTH-1:0] busWdata, // Write data of the current bus cycle.
  input wire logic [WIDTH-1:0] pinsIn, // Port pin levels, asynchronous.
  output logic [WIDTH-1:0] pinsOut, // Port pin drive values.
  output logic [WIDTH-1:0] pinsOe, // Port pin output enables.
  output logic readHit, // Current address selects a port register.
  output logic [WIDTH-1:0] readValue // Port register read value.
);
  import sysctl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] pinMeta;
    logic [WIDTH-1:0] pinSync;
  } port_s;

  port_s c;
  port_s d;
  logic [WIDTH-1:0] pinLevel;

  // ==========================================================
  // Register writes and pin synchroniser.
  always_comb begin
    d = c;
    d.pinMeta = pinsIn;
    d.pinSync = c.pinMeta;
    if (busWrite && busAddr == PORT_DIR_ADDR) begin
      d.dir = busWdata;
    end
    if (busWrite && busAddr == PORT_OUT_ADDR) begin
      d.out = busWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '{dir: PORT_DIR_RESET[WIDTH-1:0], out: PORT_OUT_RESET[WIDTH-1:0],
             pinMeta: '0, pinSync: '0};
    end else if (clkEn) begin
      c <= d;
    end
  end

  // ==========================================================
  // Per-bit drive and read-back.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign pinsOut[i] = c.out[i];
    assign pinsOe[i] = c.dir[i];
    assign pinLevel[i] = c.dir[i] ? c.out[i] : c.pinSync[i];
  end

  assign readHit = (busAddr == PORT_DIR_ADDR) || (busAddr == PORT_OUT_ADDR);
  assign readValue = (busAddr == PORT_DIR_ADDR) ? c.dir : pinLevel;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge core_clk iff clkEn); endclocking
  default disable iff (!rst_n);

  a_dir_write_lands: assert property ((busWrite && busAddr == PORT_DIR_ADDR) |=>
    (pinsOe == $past(busWdata))) else $error("direction write lost");
  a_out_write_lands: assert property ((busWrite && busAddr == PORT_OUT_ADDR) |=>
    (pinsOut == $past(busWdata))) else $error("output write lost");
  a_dir_holds: assert property ((!busWrite || busAddr != PORT_DIR_ADDR) |=>
    $stable(pinsOe)) else $error("direction changed without write");
  c_port_write: cover property (busWrite && busAddr == PORT_OUT_ADDR);

endmodule : io_port

//--- cpu_sysctl.sv
// Reset, interrupt entry, bus drive and port control of an 8-bit processor.
`timescale 1ns/1ps
module cpu_sysctl #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic core_clk, // System clock.
  input wire logic rst_n, // Asynchronous logic reset, active low.
  input wire logic clkEn, // One processor cycle per enabled edge.
  input wire logic reset_in_n, // Processor reset pin, active low.
  input wire logic irqPin_n, // Interrupt request pin, active low.
  input wire logic address_bus_drive_enable, // Address bus drive enable pin.
  input wire logic [15:0] coreAddr, // Execution unit bus address.
  input wire logic coreWrite, // Execution unit requests a write.
  input wire logic [7:0] coreWdata, // Execution unit write data.
  input wire logic instrDone, // Last cycle of the current instruction.
  input wire logic [15:0] pcIn, // Program counter to stack.
  input wire logic [7:0] statusIn, // Processor status register.
  input wire logic [7:0] spIn, // Stack pointer.
  input wire logic [7:0] dataIn, // Data bus input levels.
  input wire logic [PORT_WIDTH-1:0] peripheral_port_pins_in, // Port pin levels.
  output logic [15:0] addrOut, // Address bus value.
  output logic addrOe, // Address bus output enable.
  output logic [7:0] dataOut, // Data bus value.
  output logic dataOe, // Data bus output enable.
  output logic readWrite, // High for read, low for write.
  output logic [7:0] rdData, // Read data of the previous bus cycle.
  output logic coreRun, // Execution unit may run.
  output logic pcLoad, // Load the program counter.
  output logic [15:0] pcValue, // New program counter.
  output logic setIrqMask, // Set the interrupt mask flag.
  output logic spLoad, // Load the stack pointer.
  output logic [7:0] spValue, // New stack pointer.
  output logic [PORT_WIDTH-1:0] peripheral_port_pins_out, // Port drive values.
  output logic [PORT_WIDTH-1:0] peripheral_port_pins_oe // Port output enables.
);
  import sysctl_pkg::*;

  typedef struct packed {
    ctl_state_e st;
    logic [2:0] cnt;
    logic [15:0] vecBase;
    logic [7:0] vecLo;
    logic [15:0] pcSave;
    logic [7:0] psSave;
    logic [7:0] spSave;
    logic resMeta;
    logic resSync;
    logic irqMeta;
    logic irqSync;
    logic aecMeta;
    logic aecSync;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdData;
    logic pcLoad;
    logic [15:0] pcValue;
    logic setMask;
    logic spLoad;
    logic [7:0] spValue;
  } ctl_s;

  ctl_s c;
  ctl_s d;
  logic portHit;
  logic [PORT_WIDTH-1:0] portValue;
  logic irqTaken;

  // ==========================================================
  // Peripheral port.
  io_port #(.WIDTH(PORT_WIDTH)) u_port (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .busAddr(c.addr),
    .busWrite(c.wr),
    .busWdata(c.wdata[PORT_WIDTH-1:0]),
    .pinsIn(peripheral_port_pins_in),
    .pinsOut(peripheral_port_pins_out),
    .pinsOe(peripheral_port_pins_oe),
    .readHit(portHit),
    .readValue(portValue)
  );

  // ==========================================================
  // Sequencer.
  assign irqTaken = instrDone && !c.irqSync && !statusIn[IRQ_MASK_BIT];

  always_comb begin
    d = c;
    d.resMeta = reset_in_n;
    d.resSync = c.resMeta;
    d.irqMeta = irqPin_n;
    d.irqSync = c.irqMeta;
    d.aecMeta = address_bus_drive_enable;
    d.aecSync = c.aecMeta;
    d.wr = 1'b0;
    d.pcLoad = 1'b0;
    d.setMask = 1'b0;
    d.spLoad = 1'b0;
    d.rdData = portHit ? 8'(portValue) : dataIn;
    case (c.st)
      ST_HOLD: begin
        if (c.resSync) begin
          d.st = ST_INIT;
          d.cnt = 3'h0;
        end
      end
      ST_INIT: begin
        if (c.cnt == INIT_CYCLES - 3'h1) begin
          d.st = ST_VECLO;
          d.setMask = 1'b1;
        end else begin
          d.cnt = c.cnt + 3'h1;
        end
      end
      ST_VECLO: begin
        d.addr = c.vecBase;
        d.st = ST_VECHI;
      end
      ST_VECHI: begin
        d.addr = c.vecBase + 16'h0001;
        d.vecLo = dataIn;
        d.st = ST_VECEND;
      end
      ST_VECEND: begin
        d.pcLoad = 1'b1;
        d.pcValue = {dataIn, c.vecLo};
        d.st = ST_RUN;
      end
      ST_RUN: begin
        d.addr = coreAddr;
        d.wr = coreWrite;
        d.wdata = coreWdata;
        if (irqTaken) begin
          d.st = ST_PUSH1;
          d.pcSave = pcIn;
          d.psSave = statusIn;
          d.spSave = spIn;
        end
      end
      ST_PUSH1: begin
        d.addr = {STACK_PAGE, c.spSave};
        d.wr = 1'b1;
        d.wdata = c.pcSave[15:8];
        d.st = ST_PUSH2;
      end
      ST_PUSH2: begin
        d.addr = {STACK_PAGE, c.spSave - 8'h01};
        d.wr = 1'b1;
        d.wdata = c.pcSave[7:0];
        d.st = ST_PUSH3;
      end
      ST_PUSH3: begin
        d.addr = {STACK_PAGE, c.spSave - 8'h02};
        d.wr = 1'b1;
        d.wdata = c.psSave;
        d.setMask = 1'b1;
        d.spLoad = 1'b1;
        d.spValue = c.spSave - STACK_PUSHES;
        d.vecBase = IRQ_VEC;
        d.st = ST_VECLO;
      end
      default: begin
        d.st = ST_HOLD;
      end
    endcase
    if (!c.resSync) begin
      d.st = ST_HOLD;
      d.wr = 1'b0;
      d.vecBase = RESET_VEC;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '{st: ST_HOLD, vecBase: RESET_VEC, default: '0};
    end else if (clkEn) begin
      c <= d;
    end
  end

  // ==========================================================
  // Pin and core outputs.
  assign addrOut = c.addr;
  assign addrOe = c.aecSync;
  assign dataOut = c.wdata;
  assign dataOe = c.wr;
  assign readWrite = !c.wr;
  assign rdData = c.rdData;
  assign coreRun = (c.st == ST_RUN);
  assign pcLoad = c.pcLoad;
  assign pcValue = c.pcValue;
  assign setIrqMask = c.setMask;
  assign spLoad = c.spLoad;
  assign spValue = c.spValue;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge core_clk iff clkEn); endclocking
  default disable iff (!rst_n);

  a_hold_no_write: assert property ((c.st == ST_HOLD) |=> readWrite)
    else $error("write during reset hold");
  a_edge_starts_init: assert property ((c.st == ST_HOLD && c.resSync) |=>
    (c.st == ST_INIT)) else $error("reset sequence did not start");
  a_init_six_cycles: assert property ($rose(c.st == ST_INIT) |->
    (c.st == ST_INIT)[*6] ##1 (c.st == ST_VECLO && setIrqMask)
    ##1 (addrOut == RESET_VEC) ##1 (addrOut == RESET_VEC + 16'h0001) ##1 pcLoad)
    else $error("reset init or vector fetch wrong");
  a_irq_masked_ignored: assert property ((c.st == ST_RUN && instrDone && c.resSync &&
    statusIn[IRQ_MASK_BIT]) |=> (c.st != ST_PUSH1))
    else $error("masked request entered");
  a_irq_waits_instr: assert property ((c.st == ST_RUN && !instrDone) |=>
    (c.st != ST_PUSH1)) else $error("request taken mid-instruction");
  a_irq_stack_push: assert property ((c.st == ST_RUN && irqTaken && c.resSync) |=>
    ##1 (!readWrite && dataOut == $past(pcIn[15:8], 2) &&
      addrOut == {STACK_PAGE, $past(spIn, 2)})
    ##1 (!readWrite && dataOut == $past(pcIn[7:0], 3))
    ##1 (!readWrite && dataOut == $past(statusIn, 4) && setIrqMask))
    else $error("stacking sequence wrong");
  a_irq_vector: assert property ((c.st == ST_PUSH3 && c.resSync) |=>
    ##1 (addrOut == IRQ_VEC) ##1 (addrOut == IRQ_VEC + 16'h0001) ##1 pcLoad)
    else $error("interrupt vector fetch wrong");
  a_addr_float: assert property ($past(rst_n, 2) |->
    (addrOe == $past(address_bus_drive_enable, 2)))
    else $error("address drive does not follow its enable pin");
  a_rw_only_writes: assert property (!readWrite |-> $past(c.st == ST_RUN && coreWrite ||
    c.st == ST_PUSH1 || c.st == ST_PUSH2 || c.st == ST_PUSH3))
    else $error("read/write low outside a write");
  c_reset_seq: cover property ((c.st == ST_VECEND) ##1 pcLoad);
  c_irq_entry: cover property ((c.st == ST_PUSH3) ##4 pcLoad);
  c_irq_masked: cover property (c.st == ST_RUN && instrDone && !c.irqSync &&
    statusIn[IRQ_MASK_BIT]);

endmodule : cpu_sysctl

//--- bus_memory_model.sv
// Behavioural memory on the processor bus, holding the reset and interrupt vectors.
`timescale 1ns/1ps
module bus_memory_model (
  input wire logic core_clk, // System clock.
  input wire logic [15:0] addrOut, // Address bus.
  input wire logic addrOe, // Address bus driven.
  input wire logic readWrite, // High read, low write.
  input wire logic [7:0] dataOut, // Write data.
  output logic [7:0] dataIn // Read data.
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastQ;
  int wrCount;
  // ====================
  // Contents.
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    mem[16'hfffc] = 8'h34;
    mem[16'hfffd] = 8'h12;
    mem[16'hfffe] = 8'hcd;
    mem[16'hffff] = 8'hab;
    wrCount = 0;
    lastQ = 8'h00;
  end
  // ====================
  // Bus cycles.
  // A floating address bus selects nothing, so reads show the inverse of the last value.
  always_comb dataIn = addrOe ? mem[addrOut] : ~lastQ;
  always @(posedge core_clk) begin
    lastQ <= dataIn;
    if (!readWrite && addrOe) begin
      mem[addrOut] <= dataOut;
      wrCount <= wrCount + 1;
    end
  end
endmodule : bus_memory_model

//--- cpu_sysctl_tb_top.sv
// Self-checking testbench of the processor system-control and port logic.
`timescale 1ns/1ps
module cpu_sysctl_tb_top;
  import sysctl_pkg::*;
  logic core_clk, rst_n, clkEn, reset_in_n, irqPin_n, address_bus_drive_enable;
  logic [15:0] coreAddr, pcIn, addrOut, pcValue;
  logic coreWrite, instrDone, addrOe, dataOe, readWrite, coreRun, pcLoad, setIrqMask, spLoad;
  logic [7:0] coreWdata, statusIn, spIn, dataIn, dataOut, rdData, spValue, pinsIn, pinsOut, pinsOe;
  int errTotal = 0;
  int nCompared = 0;
  cpu_sysctl #(.PORT_WIDTH(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .reset_in_n(reset_in_n), .irqPin_n(irqPin_n),
    .address_bus_drive_enable(address_bus_drive_enable), .coreAddr(coreAddr),
    .coreWrite(coreWrite), .coreWdata(coreWdata), .instrDone(instrDone), .pcIn(pcIn),
    .statusIn(statusIn), .spIn(spIn), .dataIn(dataIn), .peripheral_port_pins_in(pinsIn),
    .addrOut(addrOut), .addrOe(addrOe), .dataOut(dataOut), .dataOe(dataOe),
    .readWrite(readWrite), .rdData(rdData), .coreRun(coreRun), .pcLoad(pcLoad),
    .pcValue(pcValue), .setIrqMask(setIrqMask), .spLoad(spLoad), .spValue(spValue),
    .peripheral_port_pins_out(pinsOut), .peripheral_port_pins_oe(pinsOe));
  bus_memory_model i_mem (.core_clk(core_clk), .addrOut(addrOut), .addrOe(addrOe),
    .readWrite(readWrite), .dataOut(dataOut), .dataIn(dataIn));
  // ====================
  // Helpers.
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errTotal++;
    end
  endtask : chk
  task automatic waitHi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask : waitHi
  task automatic busOp(input logic [15:0] a, input logic w, input logic [7:0] d);
    coreAddr = a;
    coreWrite = w;
    coreWdata = d;
    cyc(1);
    coreWrite = 1'b0;
    coreAddr = 16'h0300;
  endtask : busOp
  task automatic summarize;
    $display("compared=%0d mismatches=%0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // ====================
  // Scenarios.
  task automatic t_reset;
    int n;
    coreAddr = 16'h0200;
    coreWrite = 1'b1;
    repeat (4) begin
      cyc(1);
      chk(readWrite, 1'b1);
    end
    busOp(16'h0300, 1'b0, 8'h00);
    chk(16'(i_mem.wrCount), 16'h0000);
    reset_in_n = 1'b1;
    waitHi(setIrqMask, n);
    chk(n >= 8 && n <= 12, 1'b1);
    waitHi(pcLoad, n);
    chk(16'(n), 16'h0003);
    chk(pcValue, 16'h1234);
    chk(coreRun, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_write;
    busOp(16'h0234, 1'b1, 8'h5e);
    chk(readWrite, 1'b0);
    chk(dataOe, 1'b1);
    chk(addrOut, 16'h0234);
    chk(dataOut, 8'h5e);
    cyc(1);
    chk(readWrite, 1'b1);
    chk(i_mem.mem[16'h0234], 8'h5e);
    $display("t_write done");
  endtask : t_write
  task automatic t_port;
    busOp(PORT_DIR_ADDR, 1'b1, 8'h0f);
    cyc(1);
    busOp(PORT_OUT_ADDR, 1'b1, 8'ha5);
    cyc(2);
    chk(pinsOe, 8'h0f);
    chk(pinsOut, 8'ha5);
    busOp(PORT_OUT_ADDR, 1'b0, 8'h00);
    cyc(1);
    chk(rdData, 8'h35);
    busOp(PORT_DIR_ADDR, 1'b0, 8'h00);
    cyc(1);
    chk(rdData, 8'h0f);
    pinsIn = 8'hc3;
    cyc(3);
    busOp(PORT_OUT_ADDR, 1'b0, 8'h00);
    cyc(1);
    chk(rdData, 8'hc5);
    $display("t_port done");
  endtask : t_port
  task automatic t_irq;
    int n;
    statusIn = 8'h20;
    pcIn = 16'h4321;
    spIn = 8'hff;
    irqPin_n = 1'b0;
    cyc(4);
    chk(coreRun, 1'b1);
    statusIn = 8'h04;
    instrDone = 1'b1;
    cyc(1);
    instrDone = 1'b0;
    cyc(4);
    chk(coreRun, 1'b1);
    statusIn = 8'h20;
    instrDone = 1'b1;
    cyc(1);
    instrDone = 1'b0;
    chk(coreRun, 1'b0);
    waitHi(setIrqMask, n);
    chk(spLoad, 1'b1);
    chk(spValue, 8'hfc);
    irqPin_n = 1'b1;
    waitHi(pcLoad, n);
    chk(16'(n), 16'h0003);
    chk(pcValue, 16'habcd);
    chk({i_mem.mem[16'h01ff], i_mem.mem[16'h01fe]}, 16'h4321);
    chk(i_mem.mem[16'h01fd], 8'h20);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_aec;
    address_bus_drive_enable = 1'b0;
    clkEn = 1'b0;
    cyc(3);
    chk(addrOe, 1'b1);
    clkEn = 1'b1;
    cyc(3);
    chk(addrOe, 1'b0);
    address_bus_drive_enable = 1'b1;
    cyc(3);
    chk(addrOe, 1'b1);
    $display("t_aec done");
  endtask : t_aec
  task automatic t_rerun;
    int n;
    int w;
    coreAddr = 16'h0240;
    coreWrite = 1'b1;
    coreWdata = 8'h77;
    reset_in_n = 1'b0;
    cyc(4);
    chk(readWrite, 1'b1);
    chk(coreRun, 1'b0);
    w = i_mem.wrCount;
    cyc(4);
    chk(16'(i_mem.wrCount - w), 16'h0000);
    coreWrite = 1'b0;
    reset_in_n = 1'b1;
    waitHi(pcLoad, n);
    chk(16'(n), 16'h000c);
    chk(pcValue, 16'h1234);
    $display("t_rerun done");
  endtask : t_rerun
  // ====================
  // Clock, sequence and watchdog.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    errTotal++;
    summarize();
  end
  initial begin
    {rst_n, reset_in_n, coreWrite, instrDone} = 4'h0;
    {clkEn, irqPin_n, address_bus_drive_enable} = 3'h7;
    coreAddr = 16'h0300;
    coreWdata = 8'h00;
    pcIn = 16'h0000;
    statusIn = 8'h00;
    spIn = 8'hff;
    pinsIn = 8'h3c;
    cyc(12);
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_port();
    t_irq();
    t_aec();
    t_rerun();
    summarize();
  end
endmodule : cpu_sysctl_tb_top
